//--- smi_indicator.sv
// Front-panel lamps, reset handling and supervision for the signal monitor
`timescale 1ns/1ns
`default_nettype none
`include "smi_regs.svh"
module smi_indicator #(
  parameter int unsigned MS_DIV = `SMI_CLK_HZ / `SMI_MS_PER_S,
  parameter int unsigned SAMPLE_DIV = `SMI_CLK_HZ / `SMI_SAMPLE_HZ
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic reset_button_pin,
  input wire logic external_reset_pin,
  input wire logic mpu_alive_pin,
  input wire logic supply_good_pin,
  input wire logic supervisor_latch_cfg,
  input wire logic line_low_detected,
  input wire logic min_flash_active,
  input wire logic line_below_80v,
  input wire logic line_below_wd_level,
  input wire logic supervision_enable_switch,
  input wire logic red_enable_active,
  input wire logic special_function1_active,
  input wire logic special_function2_active,
  input wire logic external_event_input,
  input wire logic card_missing,
  input wire logic supply_24v_fault,
  input wire logic controller_wd_fault,
  input wire logic conflict_fault,
  input wire logic absence_fault,
  input wire logic dual_fault,
  input wire logic sequence_fault,
  input wire logic recurring_pulse_fault,
  input wire logic memory_test_fault,
  input wire smi_pkg::smi_lamps_t field_active,
  input wire smi_pkg::smi_lamps_t fault_channels,
  output logic line_power_lamp,
  output logic supply_fault_lamp,
  output logic controller_supervision_lamp,
  output logic conflict_lamp,
  output logic diagnostic_lamp,
  output logic absence_lamp,
  output logic dual_indication_lamp,
  output logic sequence_lamp,
  output logic card_absent_lamp,
  output logic recurring_pulse_lamp,
  output smi_pkg::smi_lamps_t channel_lamps,
  output logic relay_energized,
  output logic stop_time,
  output logic monitor_failed,
  output logic monitor_reset_pulse,
  output logic sample_strobe,
  output logic diag_mode,
  output logic [1:0] diag_event
);
  import smi_pkg::*;

  // Three-stage synchronisers for pins; index 0 button, 1 ext, 2 mpu, 3 supply
  logic [2:0] sync_reg [4];
  logic [3:0] pin_reg;
  logic [3:0] pins;
  assign pins = {supply_good_pin, mpu_alive_pin, external_reset_pin,
                 reset_button_pin};

  // Stage 1 feeds only stage 2; state changes when stages 2 and 3 agree
  always_ff @(posedge core_clk) begin
    for (int i = 0; i < 4; i++) begin
      sync_reg[i] <= {sync_reg[i][1:0], pins[i]};
      if (rst) begin
        pin_reg[i] <= (i == 3) ? 1'b1 : 1'b0;
      end else if (sync_reg[i][1] == sync_reg[i][2]) begin
        pin_reg[i] <= sync_reg[i][2];
      end
    end
  end

  // Timebase: ms tick, eighth-second tick, 2 s frame of eighths
  logic [16:0] div_reg;
  logic [6:0] ms_reg;
  logic [3:0] eighth_reg;
  logic ms_tick;
  logic eighth_tick;
  assign ms_tick = (div_reg == 17'(MS_DIV - 1));
  assign eighth_tick = ms_tick && (ms_reg == 7'(`SMI_EIGHTH_MS - 1));

  // Free-running chain; every flash and timeout below counts from it
  always_ff @(posedge core_clk) begin
    if (rst) begin
      div_reg <= 17'h0;
      ms_reg <= 7'h0;
      eighth_reg <= 4'h0;
    end else begin
      div_reg <= ms_tick ? 17'h0 : div_reg + 17'h1;
      if (ms_tick) begin
        ms_reg <= eighth_tick ? 7'h0 : ms_reg + 7'h1;
      end
      if (eighth_tick) begin
        eighth_reg <= eighth_reg + 4'h1;
      end
    end
  end

  // Flash patterns: bit0 toggles each 125 ms, bit1 each 250 ms
  logic flash_4hz;
  logic flash_2hz;
  logic pulse_2s;
  assign flash_4hz = ~eighth_reg[0];
  assign flash_2hz = ~eighth_reg[1];
  assign pulse_2s = (eighth_reg == 4'h0);

  // Count of short pulses in the 2 s frame, used for the event number
  function automatic logic burst(input logic [3:0] ph, input logic [1:0] n);
    burst = ~ph[0] && ({1'b0, ph[3:1]} < {2'h0, n});
  endfunction

  // Field sampling strobe, rate chosen for 32 samples even at 64 Hz line
  logic [15:0] samp_reg;
  always_ff @(posedge core_clk) begin
    if (rst) begin
      samp_reg <= 16'h0;
      sample_strobe <= 1'b0;
    end else begin
      sample_strobe <= (samp_reg == 16'(SAMPLE_DIV - 1));
      samp_reg <= sample_strobe ? 16'h1 : samp_reg + 16'h1;
    end
  end

  // Reset requests: edge of the combined level, so a stuck input acts once
  logic req_prev_reg;
  logic req_level;
  logic btn_prev_reg;
  logic btn_edge;
  logic ext_edge;
  assign req_level = pin_reg[0] | pin_reg[1];
  assign btn_edge = pin_reg[0] & ~btn_prev_reg;
  assign ext_edge = req_level & ~req_prev_reg & ~btn_edge;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      req_prev_reg <= 1'b0;
      btn_prev_reg <= 1'b0;
    end else begin
      req_prev_reg <= req_level;
      btn_prev_reg <= pin_reg[0];
    end
  end

  // Button press when not failed drives diagnostic display instead of reset
  logic accept_reset;
  logic diag_step;
  assign diag_step = btn_edge && !monitor_failed;
  assign accept_reset = (btn_edge && monitor_failed) || ext_edge;

  // Diagnostic display: press enters at event 1, steps to 3, then leaves
  always_ff @(posedge core_clk) begin
    if (rst) begin
      diag_mode <= 1'b0;
      diag_event <= 2'h0;
    end else if (accept_reset) begin
      diag_mode <= 1'b0;
      diag_event <= 2'h0;
    end else if (diag_step) begin
      if (!diag_mode) begin
        diag_mode <= 1'b1;
        diag_event <= 2'h1;
      end else if (diag_event == 2'(`SMI_DIAG_EVENTS)) begin
        diag_mode <= 1'b0;
        diag_event <= 2'h0;
      end else begin
        diag_event <= diag_event + 2'h1;
      end
    end
  end

  // Lamp test: all lamps on for 300 ms after each accepted reset
  logic [8:0] test_ms_reg;
  logic lamp_test;
  assign lamp_test = (test_ms_reg != 9'h0);
  always_ff @(posedge core_clk) begin
    if (rst) begin
      test_ms_reg <= 9'h0;
    end else if (accept_reset) begin
      test_ms_reg <= 9'(`SMI_LAMP_TEST_MS);
    end else if (ms_tick && lamp_test) begin
      test_ms_reg <= test_ms_reg - 9'h1;
    end
  end

  // Pulse to outside detectors so their state clears too
  always_ff @(posedge core_clk) begin
    if (rst) begin
      monitor_reset_pulse <= 1'b0;
    end else begin
      monitor_reset_pulse <= accept_reset;
    end
  end

  // Processor supervisor: ms since last edge of the alive line
  logic mpu_prev_reg;
  logic mpu_edge;
  logic [8:0] sup_ms_reg;
  logic sup_trip_reg;
  assign mpu_edge = pin_reg[2] ^ mpu_prev_reg;
  always_ff @(posedge core_clk) begin
    if (rst) begin
      mpu_prev_reg <= 1'b0;
      sup_ms_reg <= 9'h0;
      sup_trip_reg <= 1'b0;
    end else begin
      mpu_prev_reg <= pin_reg[2];
      if (mpu_edge) begin
        sup_ms_reg <= 9'h0;
        // Latching build holds the trip until power-up reset
        if (!supervisor_latch_cfg) begin
          sup_trip_reg <= 1'b0;
        end
      end else if (ms_tick && !sup_trip_reg) begin
        if (sup_ms_reg == 9'(`SMI_SUPERVISOR_MS - 1)) begin
          sup_trip_reg <= 1'b1;
        end else begin
          sup_ms_reg <= sup_ms_reg + 9'h1;
        end
      end
    end
  end

  // Internal supply failure follows the filtered power-good pin
  logic supply_fail;
  assign supply_fail = ~pin_reg[3];

  // Sticky fault flags; a new fault in the reset cycle still sets the flag
  logic [8:0] fault_in;
  logic [8:0] fault_reg;
  assign fault_in = {memory_test_fault, recurring_pulse_fault, sequence_fault,
                     dual_fault, absence_fault, conflict_fault,
                     controller_wd_fault, supply_24v_fault, 1'b0};
  always_ff @(posedge core_clk) begin
    if (rst) begin
      fault_reg <= 9'h0;
    end else begin
      fault_reg <= (accept_reset ? 9'h0 : fault_reg) | fault_in;
    end
  end

  // Latched faults drop the relay; supervisor trip or supply failure raises stop-time
  logic hw_fault;
  assign hw_fault = sup_trip_reg | supply_fail;
  always_ff @(posedge core_clk) begin
    if (rst) begin
      monitor_failed <= 1'b0;
      relay_energized <= 1'b0;
      stop_time <= 1'b0;
    end else begin
      monitor_failed <= |fault_reg[7:1];
      relay_energized <= ~(|fault_reg) & ~hw_fault;
      stop_time <= hw_fault;
    end
  end

  // Channel status display phases, timed in eighth seconds
  smi_show_t show_reg;
  logic [5:0] phase_reg;
  smi_lamps_t latched_reg;
  always_ff @(posedge core_clk) begin
    if (rst) begin
      show_reg <= SMI_SHOW_LIVE;
      phase_reg <= 6'h0;
      latched_reg <= '0;
    end else begin
      // Snapshot when the first field fault arrives; the failed flag settles
      // two cycles later, by which time the field may have moved on
      if (|fault_in[7:1] && !(|fault_reg[7:1])) begin
        latched_reg <= field_active;
      end
      case (show_reg)
        SMI_SHOW_LIVE: begin
          phase_reg <= 6'h0;
          if (monitor_failed) begin
            show_reg <= SMI_SHOW_LATCHED;
          end
        end
        SMI_SHOW_LATCHED: begin
          if (!monitor_failed) begin
            show_reg <= SMI_SHOW_LIVE;
          end else if (eighth_tick) begin
            if (phase_reg == 6'(`SMI_LATCHED_EIGHTHS - 1)) begin
              phase_reg <= 6'h0;
              show_reg <= SMI_SHOW_INVOLVED;
            end else begin
              phase_reg <= phase_reg + 6'h1;
            end
          end
        end
        SMI_SHOW_INVOLVED: begin
          if (!monitor_failed) begin
            show_reg <= SMI_SHOW_LIVE;
          end else if (eighth_tick) begin
            if (phase_reg == 6'(`SMI_INVOLVED_EIGHTHS - 1)) begin
              phase_reg <= 6'h0;
              show_reg <= SMI_SHOW_LATCHED;
            end else begin
              phase_reg <= phase_reg + 6'h1;
            end
          end
        end
        default: begin
          show_reg <= SMI_SHOW_LIVE;
          phase_reg <= 6'h0;
        end
      endcase
    end
  end

  // Absence monitoring inhibited without red enable or by preemption inputs
  logic absence_inhibit;
  assign absence_inhibit = !red_enable_active || special_function1_active ||
                           special_function2_active || external_event_input;

  // Registered lamp drive; lamp test overrides every lamp
  always_ff @(posedge core_clk) begin
    if (rst) begin
      {line_power_lamp, supply_fault_lamp, controller_supervision_lamp,
       conflict_lamp, diagnostic_lamp, absence_lamp, dual_indication_lamp,
       sequence_lamp, card_absent_lamp, recurring_pulse_lamp} <= 10'h000;
      channel_lamps <= '0;
    end else if (lamp_test) begin
      // Panel and channel lamps all forced on together
      {line_power_lamp, supply_fault_lamp, controller_supervision_lamp,
       conflict_lamp, diagnostic_lamp, absence_lamp, dual_indication_lamp,
       sequence_lamp, card_absent_lamp, recurring_pulse_lamp} <= 10'h3ff;
      channel_lamps <= '1;
    end else begin
      // Dead line wins over any flash pattern
      if (line_below_80v) begin
        line_power_lamp <= 1'b0;
      end else if (min_flash_active) begin
        line_power_lamp <= flash_4hz;
      end else if (line_low_detected) begin
        line_power_lamp <= flash_2hz;
      end else begin
        line_power_lamp <= 1'b1;
      end
      supply_fault_lamp <= fault_reg[1];
      if (fault_reg[2]) begin
        controller_supervision_lamp <= 1'b1;
      end else begin
        controller_supervision_lamp <= pulse_2s &&
          (!supervision_enable_switch || line_below_wd_level);
      end
      conflict_lamp <= fault_reg[3];
      diagnostic_lamp <= hw_fault | fault_reg[8];
      absence_lamp <= fault_reg[4] || (pulse_2s && absence_inhibit);
      dual_indication_lamp <= fault_reg[5];
      sequence_lamp <= fault_reg[6];
      card_absent_lamp <= diag_mode ? burst(eighth_reg, diag_event)
                                    : card_missing;
      recurring_pulse_lamp <= fault_reg[7];
      case (show_reg)
        SMI_SHOW_LATCHED: channel_lamps <= latched_reg;
        SMI_SHOW_INVOLVED: channel_lamps <= fault_channels;
        default: channel_lamps <= field_active;
      endcase
    end
  end
endmodule // smi_indicator
`default_nettype wire

//--- smi_regs.svh
// Timing and field constants for the signal monitor indicator block
`ifndef SMI_REGS_SVH
`define SMI_REGS_SVH
`define SMI_CLK_HZ 125000000
`define SMI_MS_PER_S 1000
`define SMI_SAMPLE_HZ 2048
`define SMI_EIGHTH_MS 125
`define SMI_LAMP_TEST_MS 300
`define SMI_SUPERVISOR_MS 300
`define SMI_LATCHED_EIGHTHS 48
`define SMI_INVOLVED_EIGHTHS 16
`define SMI_CHANNELS 16
`define SMI_LAMPS 48
`define SMI_DIAG_EVENTS 3
`endif

//--- smi_pkg.sv
// Types shared by the signal monitor indicator block
`default_nettype none
package smi_pkg;
  // Channel status display phase, one-hot
  typedef enum logic [2:0] {
    SMI_SHOW_LIVE = 3'h1,
    SMI_SHOW_LATCHED = 3'h2,
    SMI_SHOW_INVOLVED = 3'h4
  } smi_show_t;
  typedef logic [47:0] smi_lamps_t;
endpackage
`default_nettype wire

//--- smi_note_end.sv
// Intentionally empty compilation unit
`timescale 1ns/1ns

//--- smi_indicator_monitor.sv
// Concurrent checks on the indicator block ports
`timescale 1ns/1ns
`default_nettype none
module smi_indicator_monitor #(
  parameter int unsigned MS_DIV = 10,
  parameter int unsigned SAMPLE_DIV = 8
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic line_below_80v,
  input wire logic conflict_fault,
  input wire logic dual_fault,
  input wire logic line_power_lamp,
  input wire logic supply_fault_lamp,
  input wire logic controller_supervision_lamp,
  input wire logic conflict_lamp,
  input wire logic diagnostic_lamp,
  input wire logic absence_lamp,
  input wire logic dual_indication_lamp,
  input wire logic sequence_lamp,
  input wire logic card_absent_lamp,
  input wire logic recurring_pulse_lamp,
  input wire smi_pkg::smi_lamps_t channel_lamps,
  input wire logic relay_energized,
  input wire logic stop_time,
  input wire logic monitor_reset_pulse,
  input wire logic sample_strobe
);
  import smi_pkg::*;
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  logic [31:0] lt_cnt; // Cycles since the last accepted reset
  logic [15:0] s_cnt; // Cycles since the last sample strobe
  logic s_seen; // A first strobe has been seen since reset
  logic all_lit; // Every lamp on the panel is lit
  assign all_lit = &{line_power_lamp, supply_fault_lamp, conflict_lamp,
    controller_supervision_lamp, diagnostic_lamp, absence_lamp,
    dual_indication_lamp, sequence_lamp, card_absent_lamp,
    recurring_pulse_lamp, channel_lamps};
  // Lamp test age; saturates so an idle block reads as long finished
  always_ff @(posedge core_clk) begin
    if (rst) lt_cnt <= 32'hffff_ffff;
    else if (monitor_reset_pulse) lt_cnt <= 32'h0;
    else if (lt_cnt != 32'hffff_ffff) lt_cnt <= lt_cnt + 32'h1;
  end
  // Strobe spacing; the first strobe after reset has no reference
  always_ff @(posedge core_clk) begin
    if (rst) s_seen <= 1'b0;
    else if (sample_strobe) s_seen <= 1'b1;
  end
  always_ff @(posedge core_clk) begin
    if (rst || sample_strobe) s_cnt <= 16'h0;
    else s_cnt <= s_cnt + 16'h1;
  end
  // Latched fault reaches its lamp within two cycles
  sequence s_lit_soon(lamp);
    ##[1:2] lamp;
  endsequence
  a_pulse_single:
    assert property (monitor_reset_pulse |=> !monitor_reset_pulse)
    else $error("reset pulse longer than one cycle");
  a_lamp_test:
    assert property ((lt_cnt < 299 * MS_DIV - 1)
      |-> all_lit) else $error("lamp test dropped a lamp early");
  a_line_dark:
    assert property (($past(line_below_80v) && !monitor_reset_pulse &&
      lt_cnt > 301 * MS_DIV) |-> !line_power_lamp)
    else $error("line lamp lit below 80 V");
  a_stop_relay:
    assert property (stop_time |-> !relay_energized)
    else $error("relay energized during stop time");
  a_stop_diag:
    assert property (stop_time |-> diagnostic_lamp)
    else $error("diagnostic lamp dark during stop time");
  a_sample_gap:
    assert property ((sample_strobe && s_seen) |->
      s_cnt == 16'(SAMPLE_DIV - 1)) else $error("sample strobe spacing");
  a_conflict_lamp:
    assert property (conflict_fault |-> s_lit_soon(conflict_lamp))
    else $error("conflict lamp not lit");
  a_dual_lamp:
    assert property (dual_fault |-> s_lit_soon(dual_indication_lamp))
    else $error("dual indication lamp not lit");
endmodule // smi_indicator_monitor
`default_nettype wire

//--- smi_field_model.sv
// Controller heartbeat and field signal model for the indicator bench
`timescale 1ns/1ns
`default_nettype none
module smi_field_model (
  input wire logic core_clk,
  input wire logic beat_on,
  input wire logic [15:0] beat_gap,
  input wire logic [47:0] pattern,
  output logic mpu_alive_pin,
  output smi_pkg::smi_lamps_t field_active,
  output smi_pkg::smi_lamps_t fault_channels
);
  import smi_pkg::*;
  logic [15:0] gap_cnt; // Cycles since the last heartbeat edge
  // Heartbeat toggles after each gap; a hung controller simply stops
  always @(posedge core_clk) begin
    if (beat_on && gap_cnt >= beat_gap) begin
      mpu_alive_pin <= ~mpu_alive_pin;
      gap_cnt <= 16'h0;
    end else begin
      gap_cnt <= gap_cnt + 16'h1;
    end
  end
  initial begin
    mpu_alive_pin = 1'b0;
    gap_cnt = 16'h0;
  end
  // Field lamps follow the cabinet pattern; involved set is a rotation
  assign field_active = pattern;
  assign fault_channels = {pattern[23:0], pattern[47:24]};
endmodule // smi_field_model
`default_nettype wire

//--- tb_smi_indicator.sv
// Self-checking bench for the indicator block
`timescale 1ns/1ns
`default_nettype none
module tb_smi_indicator;
  import smi_pkg::*;
  logic core_clk, rst, reset_button_pin, external_reset_pin, mpu_alive_pin;
  logic supply_good_pin, supervisor_latch_cfg, line_low_detected;
  logic min_flash_active, line_below_80v, line_below_wd_level;
  logic supervision_enable_switch, red_enable_active, external_event_input;
  logic special_function1_active, special_function2_active, card_missing;
  logic supply_24v_fault, controller_wd_fault, conflict_fault, absence_fault;
  logic dual_fault, sequence_fault, recurring_pulse_fault, memory_test_fault;
  smi_lamps_t field_active, fault_channels, channel_lamps;
  logic line_power_lamp, supply_fault_lamp, controller_supervision_lamp;
  logic conflict_lamp, diagnostic_lamp, absence_lamp, dual_indication_lamp;
  logic sequence_lamp, card_absent_lamp, recurring_pulse_lamp;
  logic relay_energized, stop_time, monitor_failed, monitor_reset_pulse;
  logic sample_strobe, diag_mode, beat_on;
  logic [1:0] diag_event;
  logic [15:0] beat_gap; // Heartbeat spacing of the controller model
  logic [47:0] pattern; // Live field pattern
  logic [7:0] flt; // Fault inputs, same order as lmp
  logic [7:0] lmp; // Matching fault lamps
  int error_cnt = 0;
  int tests_run = 0;
  int n, k, tr, wd, ab;
  assign {supply_24v_fault, controller_wd_fault, conflict_fault,
    absence_fault, dual_fault, sequence_fault, recurring_pulse_fault,
    memory_test_fault} = flt;
  assign lmp = {supply_fault_lamp, controller_supervision_lamp,
    conflict_lamp, absence_lamp, dual_indication_lamp, sequence_lamp,
    recurring_pulse_lamp, diagnostic_lamp};
  // Short ms divider keeps the 300 ms and 2 s spans affordable
  smi_indicator #(.MS_DIV(10), .SAMPLE_DIV(8)) u_smi_indicator (.*);
  smi_field_model u_smi_field_model (.*);
  task automatic check(input logic [47:0] got, input logic [47:0] exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wait_n(input int c);
    repeat (c) @(negedge core_clk);
  endtask
  task automatic do_rst;
    rst = 1'b1;
    wait_n(10);
    rst = 1'b0;
    wait_n(4);
  endtask
  // Counts line lamp changes and lit cycles of the pulsed lamps
  task automatic watch(input int c, output int t, output int w,
    output int a);
    logic prev;
    t = 0;
    w = 0;
    a = 0;
    prev = line_power_lamp;
    repeat (c) begin
      @(negedge core_clk);
      t += (line_power_lamp != prev);
      prev = line_power_lamp;
      w += controller_supervision_lamp;
      a += absence_lamp;
    end
  endtask
  task automatic close_out;
    $display("checks %0d errors %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // 125 MHz clock
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  // Hang guard, sized above the roughly 80k cycles of the sequence
  initial begin
    repeat (95000) @(posedge core_clk);
    error_cnt++;
    close_out;
  end
  initial begin
    {reset_button_pin, external_reset_pin, supervisor_latch_cfg} = 3'h0;
    {line_low_detected, min_flash_active, line_below_80v} = 3'h0;
    {line_below_wd_level, special_function1_active, card_missing} = 3'h0;
    {special_function2_active, external_event_input} = 2'h0;
    {supply_good_pin, supervision_enable_switch, red_enable_active} = 3'h7;
    flt = 8'h0;
    beat_on = 1'b1;
    beat_gap = 16'h32;
    pattern = 48'h0123_4567_89ab;
    do_rst;
    check({line_power_lamp, relay_energized}, 2'h3);
    check(channel_lamps, 48'h0123_4567_89ab);
    card_missing = 1'b1;
    wait_n(5);
    check(card_absent_lamp, 1'b1);
    card_missing = 1'b0;
    // Conflict freezes the channel display at the fault snapshot
    flt = 8'h20;
    wait_n(1);
    flt = 8'h0;
    pattern = 48'hfedc_ba98_7654;
    wait_n(20);
    check(channel_lamps, 48'h0123_4567_89ab);
    check(relay_energized, 1'b0);
    // A stuck external reset must act only once
    external_reset_pin = 1'b1;
    n = 0;
    repeat (400) begin
      @(negedge core_clk);
      n += monitor_reset_pulse;
    end
    check(n, 1);
    wait_n(2500);
    check({lmp, line_power_lamp, &channel_lamps}, 10'h3ff);
    wait_n(400);
    external_reset_pin = 1'b0;
    wait_n(10);
    check({conflict_lamp, relay_energized}, 2'h1);
    check(channel_lamps, 48'hfedc_ba98_7654);
    // Button steps the diagnostic display while not failed
    for (k = 1; k < 5; k++) begin
      reset_button_pin = 1'b1;
      wait_n(8);
      reset_button_pin = 1'b0;
      wait_n(8);
      check({diag_mode, diag_event}, (k < 4) ? {1'b1, 2'(k)} : 3'h0);
    end
    wait_n(3100);
    // Flash rates and once-per-frame pulses, one 2 s frame each
    {line_low_detected, supervision_enable_switch} = 2'h2;
    red_enable_active = 1'b0;
    wait_n(10);
    watch(20000, tr, wd, ab);
    check(tr >= 7 && tr <= 9, 1'b1);
    check({wd > 1240 && wd < 1260, ab > 1240 && ab < 1260}, 2'h3);
    {min_flash_active, supervision_enable_switch} = 2'h3;
    {line_below_wd_level, red_enable_active} = 2'h3;
    special_function1_active = 1'b1;
    wait_n(10);
    watch(20000, tr, wd, ab);
    check(tr >= 15 && tr <= 17, 1'b1);
    check({wd > 1240 && wd < 1260, ab > 1240 && ab < 1260}, 2'h3);
    {line_below_80v, line_below_wd_level} = 2'h2;
    {special_function1_active, external_event_input} = 2'h1;
    wait_n(10);
    watch(20000, tr, wd, ab);
    check({tr == 0, line_power_lamp, wd == 0}, 3'h5);
    check(ab > 1240 && ab < 1260, 1'b1);
    {line_low_detected, min_flash_active, line_below_80v} = 3'h0;
    external_event_input = 1'b0;
    wait_n(10);
    check(line_power_lamp, 1'b1);
    // Slow but live controller, then a silent one
    beat_gap = 16'h7d0;
    wait_n(5000);
    check(stop_time, 1'b0);
    beat_gap = 16'h32;
    wait_n(100);
    beat_on = 1'b0;
    wait_n(2900);
    check(stop_time, 1'b0);
    wait_n(200);
    check({stop_time, relay_energized, diagnostic_lamp}, 3'h5);
    beat_on = 1'b1;
    wait_n(100);
    check(stop_time, 1'b0);
    supervisor_latch_cfg = 1'b1;
    beat_on = 1'b0;
    wait_n(3200);
    beat_on = 1'b1;
    wait_n(100);
    check(stop_time, 1'b1);
    supervisor_latch_cfg = 1'b0;
    do_rst;
    supply_good_pin = 1'b0;
    wait_n(10);
    check({stop_time, relay_energized, diagnostic_lamp}, 3'h5);
    supply_good_pin = 1'b1;
    wait_n(10);
    check(stop_time, 1'b0);
    // Each fault input lights its own lamp and no other
    for (k = 0; k < 8; k++) begin
      do_rst;
      flt = 8'h80 >> k;
      wait_n(1);
      flt = 8'h0;
      wait_n(4);
      check(lmp, 8'h80 >> k);
    end
    close_out;
  end
endmodule // tb_smi_indicator
bind smi_indicator smi_indicator_monitor #(.MS_DIV(MS_DIV),
  .SAMPLE_DIV(SAMPLE_DIV)) u_smi_indicator_monitor (.*);
`default_nettype wire
